// ---- drct_pkg.sv ----
// Package for the dual reload/capture timer: register map, fields, timing
package drct_pkg;
  localparam int          DRCT_NUM_TIMERS = 2;
  localparam int          DRCT_CNT_W      = 16;
  // Core clock is the fast internal clock; instruction cycle is a tenth of it
  localparam longint      DRCT_CORE_HZ    = 20_000_000;
  localparam longint      DRCT_IC_HZ      = 2_000_000;
  localparam int          DRCT_IC_DIV     = int'(DRCT_CORE_HZ / DRCT_IC_HZ);
  localparam logic [3:0]  DRCT_IC_LAST    = 4'(DRCT_IC_DIV - 1);
  localparam logic [3:0]  DRCT_IC_ZERO    = 4'h0;
  // Register word indices (byte address = 4 * index)
  localparam logic [3:0]  DRCT_IDX_CTRL   = 4'h0;
  localparam logic [3:0]  DRCT_IDX_COUNT  = 4'h1;
  localparam logic [3:0]  DRCT_IDX_RCA    = 4'h2;
  localparam logic [3:0]  DRCT_IDX_RCB    = 4'h3;
  localparam logic [3:0]  DRCT_IDX_STRIDE = 4'h4;
  localparam logic [3:0]  DRCT_IDX_SPEED  = 4'h8;
  // Field positions inside the control and speed words, reset values and constants
  localparam int          DRCT_CTRL_W     = 8;
  localparam int          DRCT_PWM_LVL_B  = 8;
  localparam int          DRCT_FAST_B     = 0;
  localparam logic [7:0]  DRCT_CTRL_RST   = 8'h00;
  localparam logic [7:0]  DRCT_SPEED_RST  = 8'h00;
  localparam logic [15:0] DRCT_CNT_RST    = 16'h0000;
  localparam logic [15:0] DRCT_CNT_ZERO   = 16'h0000;
  localparam logic [15:0] DRCT_CNT_ONE    = 16'h0001;
  localparam logic [31:0] DRCT_RD_ZERO    = 32'h0000_0000;
  // Mode field codes (bit2, bit1)
  localparam logic [1:0]  DRCT_MODE_PWM   = 2'b10;
  localparam logic [1:0]  DRCT_MODE_EVT   = 2'b00;

  // Control bits of one timer, packed as they sit in the control word
  typedef struct packed {
    logic       irq_enable_a;
    logic       pending_flag_a;
    logic       irq_enable_b;
    logic       pending_flag_b;
    logic [2:0] mode_select;
    logic       run_or_underflow_flag;
  } drct_ctrl_t;

  // Pin group of one timer
  typedef struct packed {
    logic level;
    logic enable;
  } drct_pin_out_t;
endpackage

// ---- drct_top.sv ----
// Dual reload/capture timer with APB register access
`timescale 1ns/100ps
// Register map, one aligned 32-bit word per register, data in the low bits:
//   timer t base is 0x10 * t
//   base + 0x0  control word
//   base + 0x4  down counter
//   base + 0x8  reload/capture register A
//   base + 0xC  reload/capture register B
//   0x20        speed control, bit 0 selects the fast clock for the second timer
// Any other address answers with an error and reads zero; writes decode bits 5:2 only, so an alias of a register writes it.
//
// Control word layout:
//   bit 0    run bit; underflow pending flag in capture mode
//   bits 3:1 mode select, bit 3 holds mode bit 2
//   bit 4    pending flag B
//   bit 5    interrupt enable B
//   bit 6    pending flag A
//   bit 7    interrupt enable A
//   bit 8    pin A output level, writable and toggled by hardware
//
// Bus timing:
//   Zero wait states; ready follows select and enable directly.
//   Read data and the error bit are latched in the setup cycle.
//   Writes take effect at the edge that closes the access phase.
//
// Timing hazards a user must know:
//   Pin edges pass two synchroniser stages and are then sampled at the
//   counting rate, so an edge is seen three to about twelve cycles late.
//   A software write to the counter beats a step in the same cycle.
//   A capture beats a software write to the same reload register.
//   Pending flags are cleared by writing zero; a hardware set in the same
//   cycle wins so no event is lost.
//
module drct_top (
  input  wire logic                                     core_clk_i,
  input  wire logic                                     rst_n_i,
  input  wire logic                                     psel_i,
  input  wire logic                                     penable_i,
  input  wire logic                                     pwrite_i,
  input  wire logic [7:0]                               paddr_i,
  input  wire logic [31:0]                              pwdata_i,
  output logic      [31:0]                              prdata_o,
  output logic                                          pready_o,
  output logic                                          pslverr_o,
  input  wire logic [drct_pkg::DRCT_NUM_TIMERS-1:0]     timer_pin_a_i,
  output drct_pkg::drct_pin_out_t [drct_pkg::DRCT_NUM_TIMERS-1:0] timer_pin_a_o,
  input  wire logic [drct_pkg::DRCT_NUM_TIMERS-1:0]     timer_pin_b_i,
  output logic      [drct_pkg::DRCT_NUM_TIMERS-1:0]     irq_a_o,
  output logic      [drct_pkg::DRCT_NUM_TIMERS-1:0]     irq_b_o
);
  import drct_pkg::*;

  logic [3:0]  ic_cnt_reg;
  logic        ic_tick;
  logic [7:0]  speed_reg;
  logic [3:0]  word_idx;
  logic        wr_acc;
  logic        setup;
  logic [31:0] rd_next;
  logic        err_next;
  logic [31:0] rd_reg;
  logic        err_reg;

  logic [DRCT_CNT_W-1:0] count_reg  [DRCT_NUM_TIMERS];
  logic [DRCT_CNT_W-1:0] rca_reg    [DRCT_NUM_TIMERS];
  logic [DRCT_CNT_W-1:0] rcb_reg    [DRCT_NUM_TIMERS];
  drct_ctrl_t            ctrl_reg   [DRCT_NUM_TIMERS];
  logic                  pwm_lvl_reg[DRCT_NUM_TIMERS];

  assign word_idx = paddr_i[5:2];
  assign setup    = psel_i & ~penable_i;
  assign wr_acc   = psel_i & penable_i & pwrite_i;

  // Instruction-cycle tick, one core cycle in ten
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ic_cnt_reg <= DRCT_IC_ZERO;
    end else if (ic_cnt_reg == DRCT_IC_LAST) begin
      ic_cnt_reg <= DRCT_IC_ZERO;
    end else begin
      ic_cnt_reg <= ic_cnt_reg + 4'h1;
    end
  end
  assign ic_tick = (ic_cnt_reg == DRCT_IC_LAST);

  // Speed control register, only bit 0 is storage
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_reg <= DRCT_SPEED_RST;
    end else if (wr_acc && word_idx == DRCT_IDX_SPEED) begin
      speed_reg <= {7'h00, pwdata_i[DRCT_FAST_B]};
    end
  end

  for (genvar t = 0; t < DRCT_NUM_TIMERS; t++) begin : g_tmr
    logic       rate_tick;
    logic       a_s1_reg, a_s2_reg, a_prev_reg;
    logic       b_s1_reg, b_s2_reg, b_prev_reg;
    logic       a_rise, a_fall, b_rise, b_fall;
    logic       is_pwm, is_evt, is_cap;
    logic       a_evt, b_evt, step, uflow;
    logic       reload_b_reg;
    logic       wr_ctrl, wr_cnt, wr_rca, wr_rcb;
    logic       set_pa, set_pb, set_uf;
    logic [3:0] base;

    assign base    = 4'(t) * DRCT_IDX_STRIDE;
    assign wr_ctrl = wr_acc && word_idx == base + DRCT_IDX_CTRL;
    assign wr_cnt  = wr_acc && word_idx == base + DRCT_IDX_COUNT;
    assign wr_rca  = wr_acc && word_idx == base + DRCT_IDX_RCA;
    assign wr_rcb  = wr_acc && word_idx == base + DRCT_IDX_RCB;

    // Counting rate: only the second timer may run on the core clock
    assign rate_tick = (t == 1 && speed_reg[DRCT_FAST_B]) ? 1'b1 : ic_tick;

    // Pin synchronisers, edges sampled at the counting rate
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        a_s1_reg   <= 1'b0;
        a_s2_reg   <= 1'b0;
        a_prev_reg <= 1'b0;
        b_s1_reg   <= 1'b0;
        b_s2_reg   <= 1'b0;
        b_prev_reg <= 1'b0;
      end else begin
        a_s1_reg <= timer_pin_a_i[t];
        a_s2_reg <= a_s1_reg;
        b_s1_reg <= timer_pin_b_i[t];
        b_s2_reg <= b_s1_reg;
        if (rate_tick) begin
          a_prev_reg <= a_s2_reg;
          b_prev_reg <= b_s2_reg;
        end
      end
    end
    assign a_rise = rate_tick & a_s2_reg & ~a_prev_reg;
    assign a_fall = rate_tick & ~a_s2_reg & a_prev_reg;
    assign b_rise = rate_tick & b_s2_reg & ~b_prev_reg;
    assign b_fall = rate_tick & ~b_s2_reg & b_prev_reg;

    // Mode decode from the three-bit field
    assign is_pwm = ctrl_reg[t].mode_select[2:1] == DRCT_MODE_PWM;
    assign is_evt = ctrl_reg[t].mode_select[2:1] == DRCT_MODE_EVT;
    assign is_cap = ctrl_reg[t].mode_select[1];
    assign a_evt  = ctrl_reg[t].mode_select[0] ? a_fall : a_rise;
    assign b_evt  = (is_cap && ctrl_reg[t].mode_select[2]) ? b_fall : b_rise;

    // Counter steps: rate in PWM, pin A edges in event mode, rate regardless of bit 0 in capture
    always_comb begin
      if (is_cap) begin
        step = rate_tick;
      end else if (is_evt) begin
        step = ctrl_reg[t].run_or_underflow_flag & a_evt;
      end else begin
        step = ctrl_reg[t].run_or_underflow_flag & rate_tick;
      end
    end
    assign uflow = step && count_reg[t] == DRCT_CNT_ZERO;

    // Flag set conditions per mode
    assign set_pa = is_pwm ? (uflow & ~reload_b_reg) : (is_evt ? uflow : a_evt);
    assign set_pb = is_pwm ? (uflow & reload_b_reg) : b_evt;
    assign set_uf = is_cap & uflow;

    // Down counter with alternating reload
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        count_reg[t] <= DRCT_CNT_RST;
      end else if (wr_cnt) begin
        count_reg[t] <= pwdata_i[DRCT_CNT_W-1:0];
      end else if (step) begin
        if (uflow && is_pwm) begin
          count_reg[t] <= reload_b_reg ? rcb_reg[t] : rca_reg[t];
        end else if (uflow && is_evt) begin
          count_reg[t] <= rca_reg[t];
        end else begin
          count_reg[t] <= count_reg[t] - DRCT_CNT_ONE;
        end
      end
    end

    // Reload selector: first reload from A, then B, A, ...
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        reload_b_reg <= 1'b0;
      end else if (wr_ctrl && !ctrl_reg[t].run_or_underflow_flag) begin
        reload_b_reg <= 1'b0;
      end else if (uflow && is_pwm) begin
        reload_b_reg <= ~reload_b_reg;
      end
    end

    // Reload/capture registers; capture wins over a software write
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        rca_reg[t] <= DRCT_CNT_RST;
        rcb_reg[t] <= DRCT_CNT_RST;
      end else begin
        if (is_cap && a_evt) begin
          rca_reg[t] <= count_reg[t];
        end else if (wr_rca) begin
          rca_reg[t] <= pwdata_i[DRCT_CNT_W-1:0];
        end
        if (is_cap && b_evt) begin
          rcb_reg[t] <= count_reg[t];
        end else if (wr_rcb) begin
          rcb_reg[t] <= pwdata_i[DRCT_CNT_W-1:0];
        end
      end
    end

    // Control bits; hardware set beats a software clear in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        ctrl_reg[t] <= drct_ctrl_t'(DRCT_CTRL_RST);
      end else begin
        if (wr_ctrl) begin
          ctrl_reg[t].irq_enable_a <= pwdata_i[7];
          ctrl_reg[t].irq_enable_b <= pwdata_i[5];
          ctrl_reg[t].mode_select  <= pwdata_i[3:1];
        end
        ctrl_reg[t].pending_flag_a <= set_pa | (wr_ctrl ? pwdata_i[6]
                                               : ctrl_reg[t].pending_flag_a);
        ctrl_reg[t].pending_flag_b <= set_pb | (wr_ctrl ? pwdata_i[4]
                                               : ctrl_reg[t].pending_flag_b);
        ctrl_reg[t].run_or_underflow_flag <= set_uf | (wr_ctrl ? pwdata_i[0]
                                               : ctrl_reg[t].run_or_underflow_flag);
      end
    end

    // Pin A output level, toggled by underflows in PWM toggle mode
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pwm_lvl_reg[t] <= 1'b0;
      end else if (uflow && is_pwm && ctrl_reg[t].mode_select[0]) begin
        pwm_lvl_reg[t] <= ~pwm_lvl_reg[t];
      end else if (wr_ctrl) begin
        pwm_lvl_reg[t] <= pwdata_i[DRCT_PWM_LVL_B];
      end
    end

    // Pin A drives only in PWM mode; pin B has no output
    assign timer_pin_a_o[t].level  = pwm_lvl_reg[t];
    assign timer_pin_a_o[t].enable = is_pwm;

    // Interrupt requests gated by enables
    assign irq_a_o[t] = ctrl_reg[t].irq_enable_a &
                        (ctrl_reg[t].pending_flag_a |
                         (is_cap & ctrl_reg[t].run_or_underflow_flag));
    assign irq_b_o[t] = ctrl_reg[t].irq_enable_b & ctrl_reg[t].pending_flag_b;
  end

  // Read mux; reads have no side effect on the counter
  always_comb begin
    rd_next  = DRCT_RD_ZERO;
    err_next = 1'b1;
    if (word_idx == DRCT_IDX_SPEED && paddr_i[7:6] == 2'b00) begin
      rd_next  = {24'h00_0000, speed_reg};
      err_next = 1'b0;
    end
    for (int k = 0; k < DRCT_NUM_TIMERS; k++) begin
      if (paddr_i[7:5] == 3'b000 && word_idx == 4'(k) * DRCT_IDX_STRIDE + DRCT_IDX_CTRL) begin
        rd_next  = {23'h00_0000, pwm_lvl_reg[k], ctrl_reg[k]};
        err_next = 1'b0;
      end
      if (paddr_i[7:5] == 3'b000 && word_idx == 4'(k) * DRCT_IDX_STRIDE + DRCT_IDX_COUNT) begin
        rd_next  = {16'h0000, count_reg[k]};
        err_next = 1'b0;
      end
      if (paddr_i[7:5] == 3'b000 && word_idx == 4'(k) * DRCT_IDX_STRIDE + DRCT_IDX_RCA) begin
        rd_next  = {16'h0000, rca_reg[k]};
        err_next = 1'b0;
      end
      if (paddr_i[7:5] == 3'b000 && word_idx == 4'(k) * DRCT_IDX_STRIDE + DRCT_IDX_RCB) begin
        rd_next  = {16'h0000, rcb_reg[k]};
        err_next = 1'b0;
      end
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_reg  <= DRCT_RD_ZERO;
      err_reg <= 1'b0;
    end else if (setup) begin
      rd_reg  <= pwrite_i ? DRCT_RD_ZERO : rd_next;
      err_reg <= err_next;
    end
  end

  assign prdata_o  = rd_reg;
  assign pready_o  = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & err_reg;
endmodule

// ---- drct_top_assertions.sv ----
// Checker of bus and pin relations of the timer block
`timescale 1ns/100ps
module drct_top_assertions
  import drct_pkg::*;
(
  input wire logic                     core_clk_i,
  input wire logic                     rst_n_i,
  input wire logic                     psel_i,
  input wire logic                     penable_i,
  input wire logic                     pwrite_i,
  input wire logic [7:0]               paddr_i,
  input wire logic [31:0]              pwdata_i,
  input wire logic [31:0]              prdata_o,
  input wire logic                     pready_o,
  input wire logic                     pslverr_o,
  input wire logic [1:0]               timer_pin_a_i,
  input wire drct_pkg::drct_pin_out_t [1:0] timer_pin_a_o,
  input wire logic [1:0]               timer_pin_b_i,
  input wire logic [1:0]               irq_a_o,
  input wire logic [1:0]               irq_b_o
);
  import drct_pkg::*;
  logic [7:0] sh [2];
  logic [1:0] wr;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence
  // Bus answers
  a_ready_nowait: assert property (s_setup ##1 s_access |-> pready_o)
    else $error("access phase without ready");
  a_unmapped_err: assert property (psel_i && penable_i && paddr_i[7:2] > 6'h08 |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
    else $error("unmapped access not refused");
  a_speed_upper: assert property (psel_i && penable_i && !pwrite_i && paddr_i[7:2] == 6'h08 |-> prdata_o[31:1] == 31'h0)
    else $error("speed register upper bits not zero");
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    assign wr[t] = psel_i & penable_i & pwrite_i & (paddr_i[7:2] == 6'(4 * t));
    // Shadow of the control bits software last wrote
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        sh[t] <= 8'h00;
      end else if (wr[t]) begin
        sh[t] <= pwdata_i[7:0];
      end
    end
    a_pin_drive: assert property (timer_pin_a_o[t].enable == (sh[t][3:2] == 2'b10))
      else $error("pin A drive does not follow mode");
    a_irq_a_gate: assert property (irq_a_o[t] |-> sh[t][7])
      else $error("irq A without enable");
    a_irq_b_gate: assert property (irq_b_o[t] |-> sh[t][5])
      else $error("irq B without enable");
    a_flag_a_hold: assert property ($fell(irq_a_o[t]) |-> $past(wr[t]))
      else $error("irq A dropped without software write");
    a_flag_b_hold: assert property ($fell(irq_b_o[t]) |-> $past(wr[t]))
      else $error("irq B dropped without software write");
    a_lvl_cause: assert property ($changed(timer_pin_a_o[t].level) |-> $past(wr[t]) || $past(sh[t][3:1]) == 3'b101)
      else $error("pin A level moved outside toggle mode");
  end
endmodule
bind drct_top drct_top_assertions u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .timer_pin_a_i(timer_pin_a_i),
  .timer_pin_a_o(timer_pin_a_o), .timer_pin_b_i(timer_pin_b_i), .irq_a_o(irq_a_o), .irq_b_o(irq_b_o)
);

// ---- drct_src_model.sv ----
// Model of the external signal sources and load on the timer pins
`timescale 1ns/100ps
module drct_src_model
  import drct_pkg::*;
(
  input  wire logic                          core_clk_i,
  input  wire drct_pkg::drct_pin_out_t [1:0] pin_drv_i,
  output logic [1:0]                         pin_a_o,
  output logic [1:0]                         pin_b_o
);
  import drct_pkg::*;
  logic [1:0] src_a;
  // Sources idle low
  initial begin
    src_a = 2'b00;
    pin_b_o = 2'b00;
  end
  // Timer wins pin A while it drives, the source otherwise
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      pin_a_o[t] = pin_drv_i[t].enable ? pin_drv_i[t].level : src_a[t];
    end
  end
  // Move one source after an edge, then let the synchroniser settle
  task automatic set_pin(input int t, input logic b, input logic v);
    @(posedge core_clk_i);
    if (b) begin
      pin_b_o[t] <= v;
    end else begin
      src_a[t] <= v;
    end
    repeat (6) @(posedge core_clk_i);
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench of the dual reload/capture timer
`timescale 1ns/100ps
module tb_top;
  import drct_pkg::*;
  logic                clk, rst_n, psel, pen, pwr, pready, pslverr, err;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, q, v;
  drct_pin_out_t [1:0] pa_o;
  logic [1:0]          pa_w, pb, irq_a, irq_b;
  int                  bad_count, cmp_count;
  drct_top DUT (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .timer_pin_a_i(pa_w), .timer_pin_a_o(pa_o), .timer_pin_b_i(pb), .irq_a_o(irq_a), .irq_b_o(irq_b));
  drct_src_model u_src (.core_clk_i(clk), .pin_drv_i(pa_o), .pin_a_o(pa_w), .pin_b_o(pb));
  // Clock of 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer: setup, then access until ready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // A slave that never answers counts as a mismatch
    if (n >= 20) begin
      bad_count++;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, q & m);
  endtask
  task automatic wait_irq(input logic b);
    int n;
    n = 0;
    while ((b ? irq_b[1] : irq_a[1]) !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("irq wait", 32'h1, 32'(n < 200));
  endtask
  task automatic t_regs;
    rdchk("speed reset", 8'h20, 32'hFFFFFFFF, 32'h0);
    rdchk("ctrl reset", 8'h10, 32'hFFFFFFFF, 32'h0);
    apb(8'h20, 1'b1, 32'hFF);
    rdchk("speed bits", 8'h20, 32'hFFFFFFFF, 32'h1);
    apb(8'h24, 1'b1, 32'h5);
    chk("unmapped wr err", 32'h1, 32'(err));
    rdchk("unmapped data", 8'h24, 32'hFFFFFFFF, 32'h0);
    chk("unmapped rd err", 32'h1, 32'(err));
  endtask
  task automatic t_slow;
    apb(8'h04, 1'b1, 32'h9);
    apb(8'h08, 1'b1, 32'h30);
    apb(8'h00, 1'b1, 32'h09);
    repeat (30) @(posedge clk);
    apb(8'h04, 1'b0, 32'h0);
    chk("slow rate", 32'h1, 32'(q >= 5 && q <= 7));
    repeat (100) @(posedge clk);
    rdchk("no toggle", 8'h00, 32'h150, 32'h040);
    chk("irq gated", 32'h0, 32'(irq_a[0]));
    apb(8'h00, 1'b1, 32'h08);
    apb(8'h04, 1'b0, 32'h0);
    v = q;
    repeat (20) @(posedge clk);
    rdchk("stopped", 8'h04, 32'hFFFF, v);
  endtask
  task automatic t_pwm;
    apb(8'h10, 1'b1, 32'h0);
    apb(8'h18, 1'b1, 32'h14);
    apb(8'h1C, 1'b1, 32'h14);
    apb(8'h14, 1'b1, 32'h2);
    apb(8'h10, 1'b1, 32'h8B);
    wait_irq(1'b0);
    chk("pin drive", 32'h1, 32'(pa_o[1].enable));
    chk("first toggle", 32'h1, 32'(pa_w[1]));
    rdchk("A reload", 8'h10, 32'h1FF, 32'h1CB);
    apb(8'h10, 1'b1, 32'h12B);
    chk("irq A off", 32'h0, 32'(irq_a[1]));
    wait_irq(1'b1);
    chk("second toggle", 32'h0, 32'(pa_w[1]));
    rdchk("B reload", 8'h10, 32'h150, 32'h010);
    apb(8'h10, 1'b1, 32'h0);
  endtask
  task automatic t_evt;
    apb(8'h14, 1'b1, 32'h1);
    apb(8'h18, 1'b1, 32'h2);
    apb(8'h10, 1'b1, 32'hA1);
    chk("no drive", 32'h0, 32'(pa_o[1].enable));
    u_src.set_pin(1, 1'b0, 1'b1);
    u_src.set_pin(1, 1'b0, 1'b0);
    rdchk("rise count", 8'h14, 32'hFFFF, 32'h0);
    chk("no underflow", 32'h0, 32'(irq_a[1]));
    u_src.set_pin(1, 1'b0, 1'b1);
    rdchk("evt reload", 8'h14, 32'hFFFF, 32'h2);
    chk("evt irq A", 32'h1, 32'(irq_a[1]));
    u_src.set_pin(1, 1'b1, 1'b1);
    chk("evt irq B", 32'h1, 32'(irq_b[1]));
    u_src.set_pin(1, 1'b1, 1'b0);
    apb(8'h10, 1'b1, 32'hA3);
    u_src.set_pin(1, 1'b0, 1'b0);
    rdchk("fall count", 8'h14, 32'hFFFF, 32'h1);
    u_src.set_pin(1, 1'b0, 1'b1);
    rdchk("rise ignored", 8'h14, 32'hFFFF, 32'h1);
    apb(8'h10, 1'b1, 32'h0);
  endtask
  task automatic t_cap;
    logic [2:0] cm [4];
    cm = '{3'b010, 3'b110, 3'b011, 3'b111};
    u_src.set_pin(1, 1'b0, 1'b0);
    apb(8'h14, 1'b1, 32'h1000);
    apb(8'h10, 1'b1, 32'h84);
    u_src.set_pin(1, 1'b0, 1'b1);
    apb(8'h18, 1'b0, 32'h0);
    chk("capture A", 32'h1, 32'(q < 32'h1000 && q > 32'h0F00));
    chk("cap irq A", 32'h1, 32'(irq_a[1]));
    apb(8'h14, 1'b0, 32'h0);
    v = q;
    apb(8'h14, 1'b0, 32'h0);
    chk("still running", 32'h1, 32'(q < v));
    u_src.set_pin(1, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(8'h10, 1'b1, 32'({cm[i], 1'b0}));
      u_src.set_pin(1, 1'b0, 1'b1);
      u_src.set_pin(1, 1'b1, 1'b1);
      rdchk("rise edges", 8'h10, 32'h50, 32'({~cm[i][0], 1'b0, ~cm[i][2], 4'h0}));
      apb(8'h10, 1'b1, 32'({cm[i], 1'b0}));
      u_src.set_pin(1, 1'b0, 1'b0);
      u_src.set_pin(1, 1'b1, 1'b0);
      rdchk("fall edges", 8'h10, 32'h50, 32'({cm[i][0], 1'b0, cm[i][2], 4'h0}));
    end
    apb(8'h10, 1'b1, 32'h0);
    apb(8'h14, 1'b1, 32'h3);
    apb(8'h10, 1'b1, 32'h84);
    repeat (10) @(posedge clk);
    rdchk("underflow flag", 8'h10, 32'h41, 32'h01);
    chk("underflow irq", 32'h1, 32'(irq_a[1]));
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Reset, then the scenarios
  initial begin
    {rst_n, psel, pen, pwr, paddr, pwdata} = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_slow();
    t_pwm();
    t_evt();
    t_cap();
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
